// ---- mscr_pkg.sv ----
// shared constants and carrier types for the status and control register bank
package mscr_pkg;
	localparam int DATA_W = 8;
	localparam int PORT_W = 8;
	localparam int AHB_AW = 8;

	// register byte offsets on the ahb-lite bus
	localparam logic [AHB_AW-1:0] OFF_WORK = 8'h00;
	localparam logic [AHB_AW-1:0] OFF_JUMP = 8'h04;
	localparam logic [AHB_AW-1:0] OFF_FLAG = 8'h08;
	localparam logic [AHB_AW-1:0] OFF_PDATA = 8'h0C;
	localparam logic [AHB_AW-1:0] OFF_PDIR = 8'h10;
	localparam logic [AHB_AW-1:0] OFF_SETUP = 8'h14;
	localparam logic [AHB_AW-1:0] OFF_BITOP = 8'h18;
	localparam logic [AHB_AW-1:0] OFF_IRQ_STAT = 8'h1C;
	localparam logic [AHB_AW-1:0] OFF_IRQ_MASK = 8'h20;

	// flag register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_SLEEP = 4;
	localparam int FLAG_WDT = 5;
	localparam int ARITH_W = 4;

	// system setup register bit positions
	localparam int SETUP_CLK_SRC = 0;
	localparam int SETUP_LOW_PWR = 1;
	localparam int SETUP_FREQ_OUT = 2;
	localparam int SETUP_PWM0 = 3;
	localparam int SETUP_PWM1 = 4;
	localparam int SETUP_PWM_RES = 5;

	// single-bit operation register fields
	localparam int BITOP_IDX_LSB = 0;
	localparam int BITOP_IDX_W = 3;
	localparam int BITOP_DIR = 3;
	localparam int BITOP_SET = 4;

	// interrupt status bit positions
	localparam int IRQ_WDT = 0;
	localparam int IRQ_HALT = 1;
	localparam int IRQ_JUMP = 2;
	localparam int IRQ_W = 3;

	// reset values
	localparam logic [DATA_W-1:0] RST_WORK = 8'h00;
	localparam logic [DATA_W-1:0] RST_SETUP = 8'h00;
	localparam logic [PORT_W-1:0] RST_PDATA = 8'h00;
	localparam logic [PORT_W-1:0] RST_PDIR = 8'hFF;
	localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

	// cycles of pipeline bubble after a jump through the low byte
	localparam int JUMP_DUMMY_CYC = 1;

	typedef enum logic [3:0] {
		OP_MOV = 4'h0,
		OP_ADD = 4'h1,
		OP_ADC = 4'h2,
		OP_SUB = 4'h3,
		OP_SBC = 4'h4,
		OP_AND = 4'h5,
		OP_OR = 4'h6,
		OP_XOR = 4'h7,
		OP_RLC = 4'h8,
		OP_RRC = 4'h9
	} mscr_op_t;

	typedef struct packed {
		logic ov;
		logic z;
		logic ac;
		logic c;
	} mscr_flags_t;

	typedef struct packed {
		mscr_op_t op;
		logic [DATA_W-1:0] a;
		logic [DATA_W-1:0] b;
	} mscr_alu_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		mscr_flags_t flags;
		mscr_flags_t upd;
	} mscr_alu_res_t;
endpackage

// ---- mscr_flag_unit.sv ----
// result and flag computation for one core operation
`timescale 1ns/1ns
`default_nettype none
module mscr_flag_unit
	import mscr_pkg::*;
(
	input wire mscr_alu_req_t req_i,
	input wire logic carry_i,
	output mscr_alu_res_t res_o
);
	logic [DATA_W-1:0] b_eff;
	logic cin;
	logic [4:0] low_sum;
	logic [8:0] sum;
	logic c_into_msb;
	logic arith;

	always_comb begin
		arith = 1'b1;
		b_eff = req_i.b;
		cin = 1'b0;
		case (req_i.op)
			OP_ADD: cin = 1'b0;
			OP_ADC: cin = carry_i;
			OP_SUB: begin
				b_eff = ~req_i.b;
				cin = 1'b1;
			end
			OP_SBC: begin
				b_eff = ~req_i.b;
				cin = carry_i;
			end
			default: arith = 1'b0;
		endcase
		// subtraction adds the complement, so carry out means no borrow
		low_sum = {1'b0, req_i.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		sum = {1'b0, req_i.a} + {1'b0, b_eff} + {8'h00, cin};
		c_into_msb = req_i.a[7] ^ b_eff[7] ^ sum[7];
		res_o = '0;
		if (arith) begin
			res_o.data = sum[7:0];
			res_o.flags.c = sum[8];
			res_o.flags.ac = low_sum[4];
			res_o.flags.ov = c_into_msb ^ sum[8];
			res_o.upd = 4'hF;
		end else begin
			case (req_i.op)
				OP_AND: res_o.data = req_i.a & req_i.b;
				OP_OR: res_o.data = req_i.a | req_i.b;
				OP_XOR: res_o.data = req_i.a ^ req_i.b;
				OP_RLC: begin
					res_o.data = {req_i.a[6:0], carry_i};
					res_o.flags.c = req_i.a[7];
				end
				OP_RRC: begin
					res_o.data = {carry_i, req_i.a[7:1]};
					res_o.flags.c = req_i.a[0];
				end
				default: res_o.data = req_i.b;
			endcase
			res_o.upd.z = (req_i.op == OP_AND) || (req_i.op == OP_OR) || (req_i.op == OP_XOR);
			res_o.upd.c = (req_i.op == OP_RLC) || (req_i.op == OP_RRC);
		end
		res_o.flags.z = (res_o.data == 8'h00);
	end
endmodule
`default_nettype wire

// ---- mscr_regs.sv ----
// core status and control register bank with ahb-lite access and port pins
// Function
// - all alu results land in working register
// - low byte write jumps within current page
// - jump through low byte adds dummy cycle
// - software writes keep watchdog and sleep flags
// - watchdog flag set on timeout, cleared by refresh or halt
// - sleep flag set by halt, cleared by refresh
// - overflow is carry-in xor carry-out of msb
// - zero flag follows result equal zero on arithmetic and logic ops
// - half-byte flag is low nibble carry
// - carry flag is carry or no borrow
// - rotate through carry updates carry flag
// - flags never saved automatically on entry
// - flag register top two bits read zero
// - arithmetic flags readable and writable
// - direction bit one input, zero output
// - data drives outputs, reads input pins
// - single-bit set and clear on port registers
// - setup register software settings reset zero
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module mscr_regs
	import mscr_pkg::*;
#(
	parameter int PORT_WIDTH = PORT_W
)(
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic hsel_i,
	input wire logic [AHB_AW-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic alu_valid_i,
	input wire mscr_alu_req_t alu_req_i,
	input wire logic [DATA_W-1:0] pc_low_i,
	input wire logic wdt_timeout_i,
	input wire logic wdt_refresh_i,
	input wire logic halt_i,
	output logic [DATA_W-1:0] working_o,
	output mscr_flags_t flags_o,
	output logic pc_jump_o,
	output logic [DATA_W-1:0] pc_target_o,
	output logic dummy_cycle_o,
	output logic [DATA_W-1:0] setup_o,
	input wire logic [PORT_WIDTH-1:0] port_pin_i,
	output logic [PORT_WIDTH-1:0] port_out_o,
	output logic [PORT_WIDTH-1:0] port_oe_o,
	output logic irq_o
);
	logic [DATA_W-1:0] working_register;
	logic [DATA_W-1:0] system_setup_register;
	logic [PORT_WIDTH-1:0] port_data_reg;
	logic [PORT_WIDTH-1:0] port_direction_reg;
	mscr_flags_t arith_flags;
	logic watchdog_expired_flag;
	logic sleep_entry_flag;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic [PORT_WIDTH-1:0] pin_meta;
	logic [PORT_WIDTH-1:0] pin_sync;
	logic [PORT_WIDTH-1:0] port_read;
	logic dp_wr;
	logic [AHB_AW-1:0] dp_addr;
	logic addr_phase;
	logic [31:0] next_rdata;
	logic [DATA_W-1:0] wbyte;
	logic [BITOP_IDX_W-1:0] bit_idx;
	logic bitop_wr;
	logic jump_wr;
	mscr_alu_res_t alu_res;

	mscr_flag_unit u_flag_unit (
		.req_i(alu_req_i),
		.carry_i(arith_flags.c),
		.res_o(alu_res)
	);

	// single cycle slave: never stretches, always okay
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign addr_phase = hsel_i && htrans_i[1] && hready_i;
	assign wbyte = hwdata_i[DATA_W-1:0];
	assign jump_wr = dp_wr && (dp_addr == OFF_JUMP);
	assign bitop_wr = dp_wr && (dp_addr == OFF_BITOP);
	assign bit_idx = wbyte[BITOP_IDX_LSB +: BITOP_IDX_W];

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dp_wr <= 1'b0;
			dp_addr <= '0;
		end else begin
			dp_wr <= addr_phase && hwrite_i;
			dp_addr <= haddr_i;
		end
	end

	// pins are asynchronous to the core clock
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= port_pin_i;
			pin_sync <= pin_meta;
		end
	end

	generate
		for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_port
			assign port_read[i] = port_direction_reg[i] ? pin_sync[i] : port_data_reg[i];
			assign port_oe_o[i] = ~port_direction_reg[i];
		end
	endgenerate
	assign port_out_o = port_data_reg;

	// core results take priority over a software write in the same cycle
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			working_register <= RST_WORK;
		end else if (alu_valid_i) begin
			working_register <= alu_res.data;
		end else if (dp_wr && dp_addr == OFF_WORK) begin
			working_register <= wbyte;
		end
	end

	// no reset on purpose: these flags power up unknown
	always_ff @(posedge ref_clk_i) begin
		if (alu_valid_i) begin
			arith_flags <= (arith_flags & ~alu_res.upd) | (alu_res.flags & alu_res.upd);
		end else if (dp_wr && dp_addr == OFF_FLAG) begin
			arith_flags <= wbyte[ARITH_W-1:0];
		end
	end

	// only core events move these; bus writes never reach them
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			watchdog_expired_flag <= 1'b0;
		end else if (wdt_timeout_i) begin
			watchdog_expired_flag <= 1'b1;
		end else if (wdt_refresh_i || halt_i) begin
			watchdog_expired_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sleep_entry_flag <= 1'b0;
		end else if (halt_i) begin
			sleep_entry_flag <= 1'b1;
		end else if (wdt_refresh_i) begin
			sleep_entry_flag <= 1'b0;
		end
	end

	// the flag register has no stack path; interrupt entry leaves it alone
	assign flags_o = arith_flags;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pc_jump_o <= 1'b0;
			pc_target_o <= '0;
			dummy_cycle_o <= 1'b0;
		end else begin
			pc_jump_o <= jump_wr;
			dummy_cycle_o <= pc_jump_o;
			if (jump_wr) begin
				pc_target_o <= wbyte;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			system_setup_register <= RST_SETUP;
		end else if (dp_wr && dp_addr == OFF_SETUP) begin
			system_setup_register <= wbyte;
		end
	end
	assign setup_o = system_setup_register;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port_data_reg <= RST_PDATA;
		end else if (dp_wr && dp_addr == OFF_PDATA) begin
			port_data_reg <= hwdata_i[PORT_WIDTH-1:0];
		end else if (bitop_wr && !wbyte[BITOP_DIR]) begin
			port_data_reg[bit_idx] <= wbyte[BITOP_SET];
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port_direction_reg <= RST_PDIR;
		end else if (dp_wr && dp_addr == OFF_PDIR) begin
			port_direction_reg <= hwdata_i[PORT_WIDTH-1:0];
		end else if (bitop_wr && wbyte[BITOP_DIR]) begin
			port_direction_reg[bit_idx] <= wbyte[BITOP_SET];
		end
	end

	assign irq_event[IRQ_WDT] = wdt_timeout_i;
	assign irq_event[IRQ_HALT] = halt_i;
	assign irq_event[IRQ_JUMP] = jump_wr;

	// a new event outranks a write-one-to-clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_status <= RST_IRQ;
			irq_mask <= RST_IRQ;
		end else begin
			if (dp_wr && dp_addr == OFF_IRQ_STAT) begin
				irq_status <= (irq_status & ~hwdata_i[IRQ_W-1:0]) | irq_event;
			end else begin
				irq_status <= irq_status | irq_event;
			end
			if (dp_wr && dp_addr == OFF_IRQ_MASK) begin
				irq_mask <= hwdata_i[IRQ_W-1:0];
			end
		end
	end
	assign irq_o = |(irq_status & irq_mask);

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (haddr_i)
			OFF_WORK: next_rdata[DATA_W-1:0] = working_register;
			OFF_JUMP: next_rdata[DATA_W-1:0] = pc_low_i;
			OFF_FLAG: next_rdata[DATA_W-1:0] = {2'b00, watchdog_expired_flag,
				sleep_entry_flag, arith_flags};
			OFF_PDATA: next_rdata[PORT_WIDTH-1:0] = port_read;
			OFF_PDIR: next_rdata[PORT_WIDTH-1:0] = port_direction_reg;
			OFF_SETUP: next_rdata[DATA_W-1:0] = system_setup_register;
			OFF_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_status;
			OFF_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// sampled at the address phase so data stands through the data phase
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (addr_phase && !hwrite_i) begin
			hrdata_o <= next_rdata;
		end
	end

	assign working_o = working_register;

	logic dp_rd;
	logic [AHB_AW-1:0] rd_addr;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dp_rd <= 1'b0;
			rd_addr <= '0;
		end else begin
			dp_rd <= addr_phase && !hwrite_i;
			rd_addr <= haddr_i;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	chk_acc_result: assert property (
		alu_valid_i |=> working_register == $past(alu_res.data))
		else $error("working register missed alu result");

	chk_jump_target: assert property (
		jump_wr |=> pc_jump_o && pc_target_o == $past(wbyte))
		else $error("low byte write gave no jump");

	chk_dummy_cycle: assert property (
		jump_wr |=> pc_jump_o ##1 dummy_cycle_o && !pc_jump_o)
		else $error("dummy cycle missing after jump");

	chk_flags_sw_ro: assert property (
		dp_wr && dp_addr == OFF_FLAG && !wdt_timeout_i && !wdt_refresh_i && !halt_i
		|=> $stable(watchdog_expired_flag) && $stable(sleep_entry_flag))
		else $error("software write moved read-only flag");

	chk_wdt_set: assert property (
		wdt_timeout_i |=> watchdog_expired_flag)
		else $error("watchdog flag not set");

	chk_wdt_clear: assert property (
		!wdt_timeout_i && (wdt_refresh_i || halt_i) |=> !watchdog_expired_flag)
		else $error("watchdog flag not cleared");

	chk_sleep_flag: assert property (
		halt_i |=> sleep_entry_flag)
		else $error("sleep flag not set by halt");
	chk_sleep_hold: assert property (
		sleep_entry_flag && !wdt_refresh_i |=> sleep_entry_flag)
		else $error("sleep flag lost without refresh");

	chk_zero_flag: assert property (
		alu_valid_i && alu_res.upd.z |=> arith_flags.z == ($past(alu_res.data) == 8'h00))
		else $error("zero flag wrong");

	chk_top_bits: assert property (
		dp_rd && rd_addr == OFF_FLAG |-> hrdata_o[7:6] == 2'b00)
		else $error("flag register top bits not zero");

	chk_port_dir: assert property (
		dp_wr && dp_addr == OFF_PDIR |=> port_oe_o == ~$past(hwdata_i[PORT_WIDTH-1:0]))
		else $error("direction write did not steer enables");

	chk_setup_write: assert property (
		dp_wr && dp_addr == OFF_SETUP |=> setup_o == $past(wbyte))
		else $error("setup register write lost");

	chk_add_carry: assert property (
		alu_valid_i && alu_req_i.op == OP_ADD
		|=> arith_flags.c == $past(int'(alu_req_i.a) + int'(alu_req_i.b) > 255))
		else $error("add carry flag wrong");
	chk_half_carry: assert property (
		alu_valid_i && alu_req_i.op == OP_ADD
		|=> arith_flags.ac == $past(int'(alu_req_i.a[3:0]) + int'(alu_req_i.b[3:0]) > 15))
		else $error("half-byte flag wrong");
	chk_add_overflow: assert property (
		alu_valid_i && alu_req_i.op == OP_ADD |=> arith_flags.ov ==
		($past(alu_req_i.a[7] == alu_req_i.b[7]) && working_register[7] != $past(alu_req_i.a[7])))
		else $error("overflow flag wrong");
	chk_rotate_carry: assert property (
		alu_valid_i && alu_req_i.op == OP_RLC |=> arith_flags.c == $past(alu_req_i.a[7]))
		else $error("rotate lost shifted bit");
	chk_flag_write: assert property (
		dp_wr && dp_addr == OFF_FLAG && !alu_valid_i
		|=> arith_flags == $past(wbyte[ARITH_W-1:0]))
		else $error("flag register write lost");
	chk_port_read: assert property (
		dp_rd && rd_addr == OFF_PDATA |-> hrdata_o[PORT_WIDTH-1:0] ==
		$past((port_direction_reg & pin_sync) | (~port_direction_reg & port_data_reg)))
		else $error("port read mixed pins and data wrongly");
	chk_bit_op: assert property (
		bitop_wr && !wbyte[BITOP_DIR]
		|=> port_data_reg[$past(bit_idx)] == $past(wbyte[BITOP_SET])
		&& $countones(port_data_reg ^ $past(port_data_reg)) <= 1)
		else $error("single-bit op touched other bits");
	chk_irq_set_wins: assert property (
		irq_event != '0 |=> (irq_status & $past(irq_event)) == $past(irq_event))
		else $error("interrupt event lost to clear");

	cov_jump: cover property (jump_wr ##1 pc_jump_o ##1 dummy_cycle_o);
	cov_add_carry: cover property (alu_valid_i && alu_req_i.op == OP_ADD && alu_res.flags.c);
	cov_halt_then_refresh: cover property (halt_i ##[1:20] wdt_refresh_i);
	cov_irq: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ---- mscr_tb.sv ----
// self-checking bench for the status and control register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
	import mscr_pkg::*;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic hsel = 1'b0;
	logic [AHB_AW-1:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic alu_valid = 1'b0;
	mscr_alu_req_t alu_req = '0;
	logic [DATA_W-1:0] pc_low = 8'h00;
	logic wdt_timeout = 1'b0;
	logic wdt_refresh = 1'b0;
	logic halt = 1'b0;
	logic [DATA_W-1:0] working;
	mscr_flags_t flags;
	logic pc_jump;
	logic [DATA_W-1:0] pc_target;
	logic dummy_cycle;
	logic [DATA_W-1:0] setup;
	logic [PORT_W-1:0] port_pin = 8'h00;
	logic [PORT_W-1:0] port_out;
	logic [PORT_W-1:0] port_oe;
	logic irq;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] rd;

	mscr_regs #(.PORT_WIDTH(PORT_W)) i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
		.hresp_o(hresp), .hrdata_o(hrdata), .alu_valid_i(alu_valid), .alu_req_i(alu_req),
		.pc_low_i(pc_low), .wdt_timeout_i(wdt_timeout), .wdt_refresh_i(wdt_refresh),
		.halt_i(halt), .working_o(working), .flags_o(flags), .pc_jump_o(pc_jump),
		.pc_target_o(pc_target), .dummy_cycle_o(dummy_cycle), .setup_o(setup),
		.port_pin_i(port_pin), .port_out_o(port_out), .port_oe_o(port_oe), .irq_o(irq));

	always #2 ref_clk_i = ~ref_clk_i;

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// a hang anywhere ends the run as a failure
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge ref_clk_i);
		while (hreadyout !== 1'b1) @(posedge ref_clk_i);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk_i);
		while (hreadyout !== 1'b1) @(posedge ref_clk_i);
		rd = hrdata;
	endtask

	task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask

	task automatic alu(input mscr_op_t op, input logic [7:0] a, input logic [7:0] b,
			input logic [7:0] exp_d, input logic [3:0] exp_f);
		@(posedge ref_clk_i);
		alu_valid <= 1'b1;
		alu_req <= '{op: op, a: a, b: b};
		@(posedge ref_clk_i);
		alu_valid <= 1'b0;
		#1;
		check("working", {24'h0, working}, {24'h0, exp_d});
		check("flags", {28'h0, flags}, {28'h0, exp_f});
	endtask

	task automatic pulse(input int which);
		@(posedge ref_clk_i);
		wdt_timeout <= (which == 0);
		halt <= (which == 1);
		wdt_refresh <= (which == 2);
		@(posedge ref_clk_i);
		wdt_timeout <= 1'b0;
		halt <= 1'b0;
		wdt_refresh <= 1'b0;
	endtask

	task automatic t_reset();
		check("hreadyout", {31'h0, hreadyout}, 32'h1);
		check("hresp", {31'h0, hresp}, 32'h0);
		check("working rst", {24'h0, working}, 32'h0);
		check("jump rst", {31'h0, pc_jump}, 32'h0);
		check("target rst", {24'h0, pc_target}, 32'h0);
		check("dummy rst", {31'h0, dummy_cycle}, 32'h0);
		check("out rst", {24'h0, port_out}, 32'h0);
		check("setup_o", {24'h0, setup}, 32'h0);
		check("oe", {24'h0, port_oe}, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		rd_check("setup", OFF_SETUP, 32'h0);
		rd_check("dir", OFF_PDIR, 32'hFF);
		bus(1'b0, OFF_FLAG, 32'h0);
		check("flag top", rd & 32'hF0, 32'h0);
		rd_check("unmapped", 8'h40, 32'h0);
	endtask

	// every op but ADD and SUB leans on the flags left by the one before
	task automatic t_alu();
		alu(OP_ADD, 8'h7F, 8'h01, 8'h80, 4'hA);
		alu(OP_AND, 8'hF0, 8'h0F, 8'h00, 4'hE);
		alu(OP_SUB, 8'h05, 8'h05, 8'h00, 4'h7);
		alu(OP_RLC, 8'h81, 8'h00, 8'h03, 4'h7);
		alu(OP_RRC, 8'h02, 8'h00, 8'h81, 4'h6);
		alu(OP_ADC, 8'hFF, 8'h01, 8'h00, 4'h7);
		alu(OP_SBC, 8'h10, 8'h01, 8'h0F, 4'h1);
		alu(OP_OR, 8'h00, 8'h00, 8'h00, 4'h5);
		alu(OP_XOR, 8'h5A, 8'h0F, 8'h55, 4'h1);
		alu(OP_ADD, 8'h80, 8'h80, 8'h00, 4'hD);
		alu(OP_MOV, 8'h00, 8'h3C, 8'h3C, 4'hD);
		rd_check("work rd", OFF_WORK, 32'h3C);
		bus(1'b1, OFF_WORK, 32'hC3);
		rd_check("work wr", OFF_WORK, 32'hC3);
	endtask

	task automatic t_flags();
		bus(1'b1, OFF_FLAG, 32'hFF);
		rd_check("flag wr", OFF_FLAG, 32'h0F);
		pulse(0);
		rd_check("flag wdt", OFF_FLAG, 32'h2F);
		bus(1'b1, OFF_FLAG, 32'h00);
		rd_check("flag keep", OFF_FLAG, 32'h20);
		pulse(1);
		rd_check("flag halt", OFF_FLAG, 32'h10);
		pulse(2);
		rd_check("flag refresh", OFF_FLAG, 32'h00);
	endtask

	task automatic t_jump();
		pc_low <= 8'h33;
		rd_check("pc low", OFF_JUMP, 32'h33);
		bus(1'b1, OFF_JUMP, 32'h5A);
		#1;
		check("jump", {31'h0, pc_jump}, 32'h1);
		check("target", {24'h0, pc_target}, 32'h5A);
		check("dummy early", {31'h0, dummy_cycle}, 32'h0);
		@(posedge ref_clk_i);
		#1;
		check("dummy", {31'h0, dummy_cycle}, 32'h1);
		check("jump end", {31'h0, pc_jump}, 32'h0);
	endtask

	task automatic t_port();
		bus(1'b1, OFF_PDIR, 32'h0F);
		bus(1'b1, OFF_PDATA, 32'hA5);
		port_pin <= 8'h3C;
		repeat (3) @(posedge ref_clk_i);
		#1;
		check("oe", {24'h0, port_oe}, 32'hF0);
		check("out", {24'h0, port_out}, 32'hA5);
		rd_check("pin read", OFF_PDATA, 32'hAC);
		bus(1'b1, OFF_BITOP, 32'h11);
		bus(1'b1, OFF_BITOP, 32'h08);
		#1;
		check("bit set", {24'h0, port_out}, 32'hA7);
		check("bit clr", {24'h0, port_oe}, 32'hF1);
		rd_check("dir bit", OFF_PDIR, 32'h0E);
		bus(1'b1, OFF_BITOP, 32'h05);
		bus(1'b1, OFF_BITOP, 32'h1F);
		#1;
		check("bit clr data", {24'h0, port_out}, 32'h87);
		check("bit set dir", {24'h0, port_oe}, 32'h71);
	endtask

	task automatic t_setup();
		bus(1'b1, OFF_SETUP, 32'h3F);
		rd_check("setup", OFF_SETUP, 32'h3F);
		check("setup_o", {24'h0, setup}, 32'h3F);
	endtask

	// status is sticky and write-one-clear; the output follows status and mask
	task automatic t_irq();
		bus(1'b1, OFF_IRQ_STAT, 32'h7);
		bus(1'b1, OFF_IRQ_MASK, 32'h0);
		rd_check("stat clr", OFF_IRQ_STAT, 32'h0);
		pulse(0);
		rd_check("stat wdt", OFF_IRQ_STAT, 32'h1);
		check("masked", {31'h0, irq}, 32'h0);
		bus(1'b1, OFF_IRQ_MASK, 32'h1);
		@(posedge ref_clk_i);
		#1;
		check("irq on", {31'h0, irq}, 32'h1);
		bus(1'b1, OFF_IRQ_STAT, 32'h1);
		@(posedge ref_clk_i);
		#1;
		check("irq off", {31'h0, irq}, 32'h0);
		rd_check("stat w1c", OFF_IRQ_STAT, 32'h0);
		pulse(1);
		rd_check("stat halt", OFF_IRQ_STAT, 32'h2);
		bus(1'b1, OFF_JUMP, 32'h12);
		rd_check("stat jump", OFF_IRQ_STAT, 32'h6);
		check("mask halt", {31'h0, irq}, 32'h0);
	endtask

	initial begin
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		t_reset();
		t_alu();
		t_flags();
		t_jump();
		t_port();
		t_setup();
		t_irq();
		finish_test();
	end
endmodule
`default_nettype wire
